// ==== pkg/slll_cfg.svh ====
/*
  constants for the segment lcd latch loader: counts, reset choices,
  build-time display options. assumes inclusion by the package and the top.
*/
`ifndef SLLL_CFG_SVH
`define SLLL_CFG_SVH

// panel geometry
`define SLLL_SEGS 40
`define SLLL_COMS 6
`define SLLL_PHASES 8
`define SLLL_LATCHES 320
`define SLLL_STROBES 32

// duty in use, 2 to 6 common phases
`define SLLL_DUTY 3'h6

// phase dwell time in ns and derived cycle count at 4 ns per cycle
`define SLLL_CLK_NS 4
`define SLLL_PHASE_NS 1024
`define SLLL_PHASE_CYC ((`SLLL_PHASE_NS + `SLLL_CLK_NS - 1) / `SLLL_CLK_NS)

// latch value after reset: 1 shows all lit, 0 all dark
`define SLLL_RESET_LIT 1'h1

// upper-left segment for digit seven: 1 on, 0 off
`define SLLL_SEVEN_F 1'h1

// flag group two bit that blanks the display
`define SLLL_BLANK_BIT 3'h4

`endif

// ==== pkg/slll_pkg.sv ====
/*
  types of the segment lcd latch loader.
  assumes slll_cfg.svh is on the include path.
*/
`include "slll_cfg.svh"

package slll_pkg;

  // pattern source of a load
  typedef enum logic [1:0] {
    OP_DECODE = 2'b00,
    OP_BLANK_DECODE = 2'b01,
    OP_RAW = 2'b10,
    OP_TABLE = 2'b11
  } slll_op_t;

  // nibble source: working register or index ram
  typedef enum logic {
    SRC_WREG = 1'b0,
    SRC_INDEX = 1'b1
  } slll_src_t;

  // one load instruction as issued by the core
  typedef struct packed {
    logic valid;
    slll_op_t op;
    slll_src_t src;
    logic multi;
    logic half;
    logic [4:0] latch_address_operand;
    logic [3:0] working_register_operand;
    logic [3:0] index_nibble;
    logic [3:0] accumulator;
    logic [7:0] table_rom_byte;
  } slll_load_t;

  // flag group two write from the core
  typedef struct packed {
    logic set_flag_group_two;
    logic reset_flag_group_two;
    logic [2:0] bit_sel;
  } slll_flag_t;

  // routing of one latch
  typedef struct packed {
    logic [2:0] line;
    logic [4:0] strobe;
  } slll_route_t;

  // whole module state
  typedef struct packed {
    logic [`SLLL_LATCHES-1:0] latch;
    logic [2:0] phase;
    logic [15:0] tick;
    logic blank;
    logic [`SLLL_SEGS-1:0] segment_pin;
    logic [`SLLL_COMS-1:0] common_pin;
  } slll_state_t;

endpackage

// ==== rtl/slll_top.sv ====
/*
  segment lcd latch loader: pattern decode, strobe decode, 320 routed
  latches, duty multiplexer and pin drive with blanking and stop.
  assumes load and flag requests come from core logic on ref_clk and that
  stop_state is a core level on ref_clk; pin levels are logical on/off.
*/
`timescale 1ns/10ps
`include "slll_cfg.svh"

module slll_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // core requests
  input wire slll_pkg::slll_load_t load_req,
  input wire slll_pkg::slll_flag_t flag_req,
  input wire logic stop_state,
  // panel drive
  output logic [`SLLL_SEGS-1:0] segment_pin,
  output logic [`SLLL_COMS-1:0] common_pin
);

  // seven segment decode, bit 0 is line a, bit 7 is line h
  function automatic logic [7:0] seg7(input logic [3:0] v);
    logic [7:0] p;
    p = 8'h00;
    unique case (v)
      4'h0: p = 8'hbf;
      4'h1: p = 8'h86;
      4'h2: p = 8'hdb;
      4'h3: p = 8'hcf;
      4'h4: p = 8'he6;
      4'h5: p = 8'hed;
      4'h6: p = 8'hfd;
      4'h7: p = {2'h2, `SLLL_SEVEN_F, 5'h07};
      4'h8: p = 8'hff;
      4'h9: p = 8'hef;
      default: p = 8'h00;
    endcase
    return p;
  endfunction

  // fixed map: line is the common phase, strobe cycles over the segments
  function automatic slll_pkg::slll_route_t route(input logic [8:0] i);
    slll_pkg::slll_route_t r;
    r.line = i[2:0];
    r.strobe = i[7:3];
    return r;
  endfunction

  slll_pkg::slll_state_t st_r;
  slll_pkg::slll_state_t st_nxt;
  logic [3:0] nibble;
  logic [7:0] pattern;
  logic [`SLLL_STROBES-1:0] strobe;

  // pattern line selection
  always_comb
  begin
    nibble = (load_req.src == slll_pkg::SRC_INDEX) ? load_req.index_nibble
                                                     : load_req.working_register_operand;
    pattern = 8'h00;
    unique case (load_req.op)
      slll_pkg::OP_DECODE: pattern = seg7(nibble);
      slll_pkg::OP_BLANK_DECODE: pattern = (nibble == 4'h0) ? 8'h00 : seg7(nibble);
      slll_pkg::OP_RAW: pattern = {load_req.accumulator, nibble};
      slll_pkg::OP_TABLE: pattern = load_req.table_rom_byte;
    endcase
  end

  // strobe decode; multi form covers one half of the address range
  always_comb
  begin
    strobe = '0;
    if (load_req.valid)
    begin
      if (load_req.multi)
        strobe = load_req.half ? 32'hffff_0000 : 32'h0000_ffff;
      else
        strobe[load_req.latch_address_operand] = 1'b1;
    end
  end

  // next state
  always_comb
  begin
    st_nxt = st_r;
    // latches load regardless of blanking
    for (int i = 0; i < `SLLL_LATCHES; i++)
    begin
      if (strobe[route(9'(i)).strobe])
        st_nxt.latch[i] = pattern[route(9'(i)).line];
    end
    // blank flag: set wins if both arrive together
    if (flag_req.reset_flag_group_two && flag_req.bit_sel == `SLLL_BLANK_BIT)
      st_nxt.blank = 1'b0;
    if (flag_req.set_flag_group_two && flag_req.bit_sel == `SLLL_BLANK_BIT)
      st_nxt.blank = 1'b1;
    // phase stepping
    if (st_r.tick == 16'(`SLLL_PHASE_CYC - 1))
    begin
      st_nxt.tick = 16'h0000;
      st_nxt.phase = (st_r.phase == `SLLL_DUTY - 3'h1) ? 3'h0 : st_r.phase + 3'h1;
    end
    else
      st_nxt.tick = st_r.tick + 16'h0001;
    // pin drive from current phase; blank and stop force ground
    st_nxt.segment_pin = '0;
    st_nxt.common_pin = '0;
    if (!stop_state && !st_r.blank)
    begin
      st_nxt.common_pin[st_r.phase] = 1'b1;
      for (int s = 0; s < `SLLL_SEGS; s++)
        st_nxt.segment_pin[s] = st_r.latch[s * `SLLL_PHASES + int'(st_r.phase)];
    end
  end

  // state register; latches preset to the reset display choice
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r.latch <= {`SLLL_LATCHES{`SLLL_RESET_LIT}};
      st_r.phase <= 3'h0;
      st_r.tick <= 16'h0000;
      st_r.blank <= 1'b0;
      st_r.segment_pin <= '0;
      st_r.common_pin <= '0;
    end
    else
      st_r <= st_nxt;
  end

  assign segment_pin = st_r.segment_pin;
  assign common_pin = st_r.common_pin;

  // checks
  sequence load_seq;
    load_req.valid && !load_req.multi;
  endsequence

  sequence quiet_seq;
    !load_req.valid;
  endsequence

  property seven_f_p;
    @(posedge ref_clk) disable iff (!arst_n)
      load_req.op == slll_pkg::OP_DECODE && nibble == 4'h7 |-> pattern[5] == `SLLL_SEVEN_F;
  endproperty

  dec_table_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_req.op == slll_pkg::OP_DECODE && nibble == 4'h0 |-> pattern == 8'hbf)
    else $error("decode of zero wrong");
  dec_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_req.op == slll_pkg::OP_DECODE && nibble > 4'h9 |-> pattern == 8'h00)
    else $error("decode above nine not blank");
  seven_f_a: assert property (seven_f_p)
    else $error("digit seven f line wrong");
  blank_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_req.op == slll_pkg::OP_BLANK_DECODE && nibble == 4'h0 |-> pattern == 8'h00)
    else $error("blanking decode not zero");
  raw_map_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_req.op == slll_pkg::OP_RAW |-> pattern == {load_req.accumulator, nibble})
    else $error("raw pattern wrong");
  strobe_one_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_seq |-> $onehot(strobe) && strobe[load_req.latch_address_operand])
    else $error("single strobe wrong");
  latch_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_seq ##0 (load_req.latch_address_operand == 5'h00) |=> st_r.latch[0] == $past(pattern[0]))
    else $error("latch zero not loaded");
  // line h only reaches an undisplayed latch, so it is watched here
  table_byte_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_seq ##0 (load_req.op == slll_pkg::OP_TABLE)
      ##0 (load_req.latch_address_operand == 5'h00)
      |=> st_r.latch[7] == $past(load_req.table_rom_byte[7]))
    else $error("table byte line h not loaded");
  dec_one_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_req.op == slll_pkg::OP_DECODE && nibble == 4'h1 |-> pattern == 8'h86)
    else $error("decode of one wrong");
  blank_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    flag_req.set_flag_group_two && flag_req.bit_sel == `SLLL_BLANK_BIT |=> st_r.blank)
    else $error("blank flag set lost");
  // phase may only move at the end of its dwell count
  phase_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r.tick != 16'(`SLLL_PHASE_CYC - 1) |=> $stable(st_r.phase))
    else $error("phase moved inside dwell");
  latch_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    quiet_seq |=> st_r.latch == $past(st_r.latch))
    else $error("latches changed without load");
  multi_strobe_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    load_req.valid && load_req.multi |-> $countones(strobe) == 16)
    else $error("multi load strobe count wrong");
  blank_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r.blank |=> segment_pin == '0 && common_pin == '0)
    else $error("blanked display drives pins");
  stop_gnd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stop_state |=> segment_pin == '0 && common_pin == '0)
    else $error("stop state left pins driven");
  com_one_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !stop_state && !st_r.blank |=> $onehot(common_pin) && st_r.phase < `SLLL_DUTY)
    else $error("common drive not one-hot");

endmodule

// ==== tb/slll_panel.sv ====
/*
  segment lcd glass model: keeps what each common phase last showed, all dark while no common is driven.
  assumes logical pin levels from the loader, sampled on ref_clk.
*/
`timescale 1ns/10ps
`include "slll_cfg.svh"

module slll_panel (
  // clock
  input wire logic ref_clk,
  // pins from the driver
  input wire logic [`SLLL_SEGS-1:0] segment_pin,
  input wire logic [`SLLL_COMS-1:0] common_pin,
  // what the glass shows
  output logic [`SLLL_COMS-1:0][`SLLL_SEGS-1:0] lit,
  output logic fault
);
  // no common driven leaves the glass dark; two commons at once would smear it
  always @(posedge ref_clk)
  begin
    for (int p = 0; p < `SLLL_COMS; p++)
    begin
      if (common_pin == '0)
        lit[p] <= '0;
      else if (common_pin[p])
        lit[p] <= segment_pin;
    end
    if (!$onehot0(common_pin))
      fault <= 1'b1;
  end

  // clean at start, sticky after
  initial fault = 1'b0;
endmodule

// ==== tb/segment_lcd_latch_loader_tb.sv ====
/*
  testbench of the segment lcd latch loader: scenario tasks against a panel.
  assumes the default routing map and build choices of the config header.
*/
`timescale 1ns/10ps
`include "slll_cfg.svh"

module segment_lcd_latch_loader_tb;
  // stimulus and observed pins
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  slll_pkg::slll_load_t lr = '0;
  slll_pkg::slll_flag_t fr = '0;
  logic stop_state = 1'b0;
  logic [`SLLL_SEGS-1:0] segment_pin;
  logic [`SLLL_COMS-1:0] common_pin;
  logic [`SLLL_COMS-1:0][`SLLL_SEGS-1:0] lit;
  logic fault;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] dec_tab [16];

  // clock
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  slll_top slll_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .load_req(lr), .flag_req(fr),
    .stop_state(stop_state), .segment_pin(segment_pin), .common_pin(common_pin));
  slll_panel slll_panel_inst (.ref_clk(ref_clk), .segment_pin(segment_pin),
    .common_pin(common_pin), .lit(lit), .fault(fault));

  // a whole frame with margin, so every phase is redrawn
  task automatic frame();
    repeat (`SLLL_PHASE_CYC * `SLLL_DUTY + 8) @(posedge ref_clk);
    #1;
  endtask

  // one-cycle load; the unused nibble source carries the inverse as a trap
  task automatic load(slll_pkg::slll_op_t op, logic mul, logic [4:0] a, logic [3:0] n,
    logic [3:0] ac, logic [7:0] rom);
    @(posedge ref_clk);
    #1;
    lr = '{1'b1, op, slll_pkg::slll_src_t'(n[0]), mul, a[4], a, n[0] ? ~n : n,
      n[0] ? n : ~n, ac, rom};
    @(posedge ref_clk);
    #1;
    lr.valid = 1'b0;
    frame();
  endtask

  // one-cycle flag pulse on the blank bit
  task automatic flag(logic set);
    @(posedge ref_clk);
    #1;
    fr = '{set, !set, `SLLL_BLANK_BIT};
    @(posedge ref_clk);
    #1;
    fr = '0;
    frame();
  endtask

  // segment s shows pattern line p in phase p
  task automatic chk(int s, logic [7:0] pat);
    for (int p = 0; p < `SLLL_DUTY; p++)
    begin
      cmp_count++;
      if (lit[p][s] !== pat[p])
        $display("wrong value seg%0d.%0d expected %b seen %b", s, p, pat[p], lit[p][s]);
      num_errors += (lit[p][s] !== pat[p]);
    end
  endtask

  task automatic t_decode();
    for (int d = 0; d < 16; d++)
    begin
      load(slll_pkg::OP_DECODE, 1'b0, 5'h03, 4'(d), 4'h0, 8'h00);
      chk(3, dec_tab[d]);
      chk(35, dec_tab[d]);
    end
    chk(4, 8'hff);
    load(slll_pkg::OP_BLANK_DECODE, 1'b0, 5'h03, 4'h0, 4'h0, 8'h00);
    chk(3, 8'h00);
    load(slll_pkg::OP_BLANK_DECODE, 1'b0, 5'h03, 4'h5, 4'h0, 8'h00);
    chk(3, dec_tab[5]);
  endtask

  task automatic t_direct();
    load(slll_pkg::OP_RAW, 1'b0, 5'h05, 4'h5, 4'ha, 8'h00);
    chk(5, 8'ha5);
    load(slll_pkg::OP_TABLE, 1'b0, 5'h06, 4'h0, 4'h0, 8'h2c);
    chk(6, 8'h2c);
    load(slll_pkg::OP_TABLE, 1'b1, 5'h10, 4'h0, 4'h0, 8'h15);
    chk(16, 8'h15);
    chk(31, 8'h15);
    chk(15, 8'hff);
  endtask

  task automatic t_blank_stop();
    flag(1'b1);
    chk(0, 8'h00);
    load(slll_pkg::OP_TABLE, 1'b0, 5'h07, 4'h0, 4'h0, 8'h3c);
    flag(1'b0);
    chk(7, 8'h3c);
    chk(6, 8'h2c);
    stop_state = 1'b1;
    frame();
    chk(5, 8'h00);
    stop_state = 1'b0;
    frame();
    chk(5, 8'ha5);
  endtask

  // single load at address zero, then the low multi half over it
  task automatic t_low_half();
    load(slll_pkg::OP_TABLE, 1'b0, 5'h00, 4'h0, 4'h0, 8'h96);
    chk(0, 8'h96);
    chk(32, 8'h96);
    load(slll_pkg::OP_RAW, 1'b1, 5'h00, 4'h3, 4'h9, 8'h00);
    chk(0, 8'h93);
    chk(39, 8'h93);
    chk(16, 8'h15);
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence; every wait is a fixed bounded count
  initial
  begin
    dec_tab = '{8'hbf, 8'h86, 8'hdb, 8'hcf, 8'he6, 8'hed, 8'hfd,
      8'h87 | {2'h0, `SLLL_SEVEN_F, 5'h00}, 8'hff, 8'hef, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    repeat (6) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    frame();
    chk(0, 8'hff);
    chk(39, 8'hff);
    t_decode();
    t_direct();
    t_blank_stop();
    t_low_half();
    cmp_count++;
    if (fault !== 1'b0)
      $display("wrong value common one-hot expected 0 seen %b", fault);
    num_errors += (fault !== 1'b0);
    print_verdict();
  end
endmodule
